// >>> hdl/hsrm_pkg.sv
package hsrm_pkg;
	localparam int HSRM_AW = 8;
	localparam int HSRM_DW = 32;
	localparam int HSRM_POS_W = 32;
	localparam int HSRM_SPD_W = 16;
	localparam int HSRM_TIME_W = 16;
	localparam int HSRM_METHOD_W = 4;
	localparam int HSRM_POINT_SEL_W = 8;

	// Register byte offsets
	localparam logic [7:0] HSRM_OFS_METHOD = 8'h00;
	localparam logic [7:0] HSRM_OFS_DIRECTION = 8'h04;
	localparam logic [7:0] HSRM_OFS_DOG_POL = 8'h08;
	localparam logic [7:0] HSRM_OFS_SEARCH_SPEED = 8'h0c;
	localparam logic [7:0] HSRM_OFS_CREEP_SPEED = 8'h10;
	localparam logic [7:0] HSRM_OFS_SHIFT = 8'h14;
	localparam logic [7:0] HSRM_OFS_HOME_VALUE = 8'h18;
	localparam logic [7:0] HSRM_OFS_PT1_ACCEL = 8'h1c;
	localparam logic [7:0] HSRM_OFS_PT1_DECEL = 8'h20;
	localparam logic [7:0] HSRM_OFS_STATUS = 8'h24;
	localparam logic [7:0] HSRM_OFS_CUR_POS = 8'h28;
	localparam logic [7:0] HSRM_OFS_LATCH_POS = 8'h2c;
	localparam logic [7:0] HSRM_OFS_CONTROL = 8'h30;

	// Homing method codes
	localparam logic [3:0] HSRM_METHOD_DOG_CRADLE = 4'h7;
	localparam logic [3:0] HSRM_METHOD_DOG_FIRST_Z = 4'h8;
	localparam logic [3:0] HSRM_METHOD_DOG_FRONT = 4'h9;

	// Reset values
	localparam logic [3:0] HSRM_RST_METHOD = 4'h7;
	localparam logic HSRM_RST_DIRECTION = 1'b0;
	localparam logic HSRM_RST_DOG_POL = 1'b0;
	localparam logic [15:0] HSRM_RST_SEARCH_SPEED = 16'h0000;
	localparam logic [15:0] HSRM_RST_CREEP_SPEED = 16'h0000;
	localparam logic [31:0] HSRM_RST_SHIFT = 32'h00000000;
	localparam logic [31:0] HSRM_RST_HOME_VALUE = 32'h00000000;
	localparam logic [15:0] HSRM_RST_PT1_ACCEL = 16'h0000;
	localparam logic [15:0] HSRM_RST_PT1_DECEL = 16'h0000;

	// Status and control field positions
	localparam int HSRM_ST_BUSY = 0;
	localparam int HSRM_ST_DONE = 1;
	localparam int HSRM_ST_ERR = 2;
	localparam int HSRM_ST_MODE_OK = 3;
	localparam int HSRM_ST_POS_SRC = 4;
	localparam int HSRM_ST_STATE_LSB = 8;
	localparam int HSRM_CTRL_CLR_ERR = 0;

	typedef enum logic [2:0] {
		HSRM_IDLE = 3'b000,
		HSRM_SEARCH = 3'b001,
		HSRM_LEAVE = 3'b010,
		HSRM_WAIT_Z = 3'b011,
		HSRM_SHIFT = 3'b100,
		HSRM_FINISH = 3'b101
	} hsrm_state_t;

	typedef struct packed {
		logic enable;
		logic dir;
		logic [15:0] speed;
		logic [15:0] accel;
		logic [15:0] decel;
	} hsrm_motion_t;
endpackage

// >>> hdl/hsrm_edge.sv
`timescale 1ns/10ps
module hsrm_edge
	import hsrm_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic din,
	input wire logic invert,
	output logic level,
	output logic rise,
	output logic fall
);
	logic prev;
	logic next_prev;

	always_comb begin
		level = din ^ invert;
		next_prev = level;
		rise = level & ~prev;
		fall = ~level & prev;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev <= 1'b0;
		end else begin
			prev <= next_prev;
		end
	end
endmodule // hsrm_edge

// >>> hdl/hsrm_reach.sv
`timescale 1ns/10ps
module hsrm_reach
	import hsrm_pkg::*;
#(
	parameter int POS_W = HSRM_POS_W
) (
	input wire logic [POS_W-1:0] pos,
	input wire logic [POS_W-1:0] target,
	input wire logic dir,
	output logic reached
);
	// Direction 0 travels toward larger positions
	always_comb begin
		if (dir) begin
			reached = $signed(pos) <= $signed(target);
		end else begin
			reached = $signed(pos) >= $signed(target);
		end
	end
endmodule // hsrm_reach

// >>> hdl/hsrm_top.sv
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
module hsrm_top
	import hsrm_pkg::*;
#(
	parameter int POS_W = HSRM_POS_W,
	parameter int SPD_W = HSRM_SPD_W,
	parameter int TIME_W = HSRM_TIME_W
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [HSRM_AW-1:0] ADDR,
	input wire logic [HSRM_DW-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [HSRM_DW-1:0] RDATA,
	input wire logic AUTO_MANUAL_SELECT_BIT,
	input wire logic [HSRM_POINT_SEL_W-1:0] POINT_SEL_BITS,
	input wire logic POS_SPEED_SOURCE_SELECT,
	input wire logic HOME_REQ,
	input wire logic DOG_IN,
	input wire logic ZPHASE_IN,
	input wire logic [POS_W-1:0] FB_POS,
	output hsrm_motion_t MOTION,
	output logic HOME_BUSY,
	output logic HOME_DONE,
	output logic HOME_ERR,
	output logic [POS_W-1:0] CUR_POS
);
	// Configuration registers
	logic [HSRM_METHOD_W-1:0] method, next_method;
	logic direction, next_direction;
	logic dog_pol, next_dog_pol;
	logic [SPD_W-1:0] search_speed, next_search_speed;
	logic [SPD_W-1:0] creep_speed, next_creep_speed;
	logic [POS_W-1:0] shift_dist, next_shift_dist;
	logic [POS_W-1:0] home_value, next_home_value;
	logic [TIME_W-1:0] pt1_accel, next_pt1_accel;
	logic [TIME_W-1:0] pt1_decel, next_pt1_decel;
	logic [HSRM_DW-1:0] next_rdata;

	// Sequencer state
	hsrm_state_t state, next_state;
	logic trav_dir, next_trav_dir;
	logic [POS_W-1:0] latch_pos, next_latch_pos;
	logic [POS_W-1:0] target, next_target;
	logic [POS_W-1:0] pos_offset, next_pos_offset;
	logic [POS_W-1:0] next_cur_pos;
	logic busy, next_busy;
	logic done, next_done;
	logic err, next_err;
	hsrm_motion_t next_motion;

	logic dog_rise, dog_fall;
	logic z_rise;
	logic reached;
	logic mode_ok;
	logic method_known;
	logic clr_err;
	logic [HSRM_DW-1:0] status_word;

	hsrm_edge u_dog_edge (
		.clk(CLK),
		.rst_n(RST_N),
		.din(DOG_IN),
		.invert(dog_pol),
		.level(),
		.rise(dog_rise),
		.fall(dog_fall)
	);

	hsrm_edge u_z_edge (
		.clk(CLK),
		.rst_n(RST_N),
		.din(ZPHASE_IN),
		.invert(1'b0),
		.level(),
		.rise(z_rise),
		.fall()
	);

	hsrm_reach #(
		.POS_W(POS_W)
	) u_reach (
		.pos(FB_POS),
		.target(target),
		.dir(trav_dir),
		.reached(reached)
	);

	// Requests that arrive outside manual mode are dropped, not queued
	assign mode_ok = AUTO_MANUAL_SELECT_BIT && (POINT_SEL_BITS == '0);
	assign method_known = (method == HSRM_METHOD_DOG_CRADLE) || (method == HSRM_METHOD_DOG_FIRST_Z)
		|| (method == HSRM_METHOD_DOG_FRONT);
	assign clr_err = WR && (ADDR == HSRM_OFS_CONTROL) && WDATA[HSRM_CTRL_CLR_ERR];

	always_comb begin
		status_word = '0;
		status_word[HSRM_ST_BUSY] = busy;
		status_word[HSRM_ST_DONE] = done;
		status_word[HSRM_ST_ERR] = err;
		status_word[HSRM_ST_MODE_OK] = mode_ok;
		status_word[HSRM_ST_POS_SRC] = POS_SPEED_SOURCE_SELECT;
		status_word[HSRM_ST_STATE_LSB +: 3] = state;
	end

	// Register file
	always_comb begin
		next_method = method;
		next_direction = direction;
		next_dog_pol = dog_pol;
		next_search_speed = search_speed;
		next_creep_speed = creep_speed;
		next_shift_dist = shift_dist;
		next_home_value = home_value;
		next_pt1_accel = pt1_accel;
		next_pt1_decel = pt1_decel;
		next_rdata = '0;
		if (WR) begin
			case (ADDR)
				HSRM_OFS_METHOD: next_method = WDATA[HSRM_METHOD_W-1:0];
				HSRM_OFS_DIRECTION: next_direction = WDATA[0];
				HSRM_OFS_DOG_POL: next_dog_pol = WDATA[0];
				HSRM_OFS_SEARCH_SPEED: next_search_speed = WDATA[SPD_W-1:0];
				HSRM_OFS_CREEP_SPEED: next_creep_speed = WDATA[SPD_W-1:0];
				HSRM_OFS_SHIFT: next_shift_dist = WDATA[POS_W-1:0];
				HSRM_OFS_HOME_VALUE: next_home_value = WDATA[POS_W-1:0];
				HSRM_OFS_PT1_ACCEL: next_pt1_accel = WDATA[TIME_W-1:0];
				HSRM_OFS_PT1_DECEL: next_pt1_decel = WDATA[TIME_W-1:0];
				default: begin
				end
			endcase
		end
		if (RD) begin
			case (ADDR)
				HSRM_OFS_METHOD: next_rdata[HSRM_METHOD_W-1:0] = method;
				HSRM_OFS_DIRECTION: next_rdata[0] = direction;
				HSRM_OFS_DOG_POL: next_rdata[0] = dog_pol;
				HSRM_OFS_SEARCH_SPEED: next_rdata[SPD_W-1:0] = search_speed;
				HSRM_OFS_CREEP_SPEED: next_rdata[SPD_W-1:0] = creep_speed;
				HSRM_OFS_SHIFT: next_rdata[POS_W-1:0] = shift_dist;
				HSRM_OFS_HOME_VALUE: next_rdata[POS_W-1:0] = home_value;
				HSRM_OFS_PT1_ACCEL: next_rdata[TIME_W-1:0] = pt1_accel;
				HSRM_OFS_PT1_DECEL: next_rdata[TIME_W-1:0] = pt1_decel;
				HSRM_OFS_STATUS: next_rdata = status_word;
				HSRM_OFS_CUR_POS: next_rdata[POS_W-1:0] = CUR_POS;
				HSRM_OFS_LATCH_POS: next_rdata[POS_W-1:0] = latch_pos;
				default: next_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			method <= HSRM_RST_METHOD;
			direction <= HSRM_RST_DIRECTION;
			dog_pol <= HSRM_RST_DOG_POL;
			search_speed <= HSRM_RST_SEARCH_SPEED;
			creep_speed <= HSRM_RST_CREEP_SPEED;
			shift_dist <= HSRM_RST_SHIFT;
			home_value <= HSRM_RST_HOME_VALUE;
			pt1_accel <= HSRM_RST_PT1_ACCEL;
			pt1_decel <= HSRM_RST_PT1_DECEL;
			RDATA <= '0;
		end else begin
			method <= next_method;
			direction <= next_direction;
			dog_pol <= next_dog_pol;
			search_speed <= next_search_speed;
			creep_speed <= next_creep_speed;
			shift_dist <= next_shift_dist;
			home_value <= next_home_value;
			pt1_accel <= next_pt1_accel;
			pt1_decel <= next_pt1_decel;
			RDATA <= next_rdata;
		end
	end

	// Homing sequencer
	always_comb begin
		next_state = state;
		next_trav_dir = trav_dir;
		next_latch_pos = latch_pos;
		next_target = target;
		next_pos_offset = pos_offset;
		next_busy = busy;
		next_done = done;
		next_err = err;
		if (clr_err) begin
			next_err = 1'b0;
		end
		case (state)
			HSRM_IDLE: begin
				if (HOME_REQ && mode_ok) begin
					if (method_known) begin
						next_state = HSRM_SEARCH;
						next_trav_dir = direction;
						next_busy = 1'b1;
						next_done = 1'b0;
					end else begin
						next_err = 1'b1;
					end
				end
			end
			HSRM_SEARCH: begin
				if (dog_rise) begin
					case (method)
						HSRM_METHOD_DOG_CRADLE: next_state = HSRM_WAIT_Z;
						HSRM_METHOD_DOG_FIRST_Z: begin
							next_state = HSRM_LEAVE;
							next_trav_dir = ~trav_dir;
						end
						default: begin
							next_latch_pos = FB_POS;
							next_state = HSRM_SHIFT;
						end
					endcase
				end
			end
			HSRM_LEAVE: begin
				if (dog_fall) begin
					next_state = HSRM_WAIT_Z;
				end
			end
			HSRM_WAIT_Z: begin
				if (z_rise) begin
					next_latch_pos = FB_POS;
					next_state = HSRM_SHIFT;
				end
			end
			HSRM_SHIFT: begin
				if (reached) begin
					next_state = HSRM_FINISH;
				end
			end
			HSRM_FINISH: begin
				// Offset makes the reported position equal the home value right here
				next_pos_offset = home_value - FB_POS;
				next_state = HSRM_IDLE;
				next_busy = 1'b0;
				next_done = 1'b1;
			end
			default: begin
				next_state = HSRM_IDLE;
				next_busy = 1'b0;
			end
		endcase
		// The target follows the travel direction in force once the reference is latched
		if (next_state == HSRM_SHIFT && state != HSRM_SHIFT) begin
			if (next_trav_dir) begin
				next_target = next_latch_pos - shift_dist;
			end else begin
				next_target = next_latch_pos + shift_dist;
			end
		end
		// Leaving manual mode mid-sequence stops the axis; set wins over a clear
		if (busy && !mode_ok) begin
			next_state = HSRM_IDLE;
			next_busy = 1'b0;
			next_err = 1'b1;
		end
		next_cur_pos = FB_POS + next_pos_offset;
		next_motion.enable = (next_state != HSRM_IDLE) && (next_state != HSRM_FINISH);
		next_motion.dir = next_trav_dir;
		next_motion.speed = (next_state == HSRM_SEARCH) ? search_speed : creep_speed;
		next_motion.accel = pt1_accel;
		next_motion.decel = pt1_decel;
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state <= HSRM_IDLE;
			trav_dir <= 1'b0;
			latch_pos <= '0;
			target <= '0;
			pos_offset <= '0;
			busy <= 1'b0;
			done <= 1'b0;
			err <= 1'b0;
			CUR_POS <= '0;
			MOTION <= '0;
		end else begin
			state <= next_state;
			trav_dir <= next_trav_dir;
			latch_pos <= next_latch_pos;
			target <= next_target;
			pos_offset <= next_pos_offset;
			busy <= next_busy;
			done <= next_done;
			err <= next_err;
			CUR_POS <= next_cur_pos;
			MOTION <= next_motion;
		end
	end

	assign HOME_BUSY = busy;
	assign HOME_DONE = done;
	assign HOME_ERR = err;
endmodule // hsrm_top

// >>> sim/hsrm_assertions.sv
`timescale 1ns/10ps
module hsrm_checker
	import hsrm_pkg::*;
#(
	parameter int POS_W = HSRM_POS_W
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic WR,
	input wire logic AUTO_MANUAL_SELECT_BIT,
	input wire logic [HSRM_POINT_SEL_W-1:0] POINT_SEL_BITS,
	input wire logic HOME_REQ,
	input wire logic [POS_W-1:0] FB_POS,
	input wire hsrm_motion_t MOTION,
	input wire logic HOME_BUSY,
	input wire logic HOME_DONE,
	input wire logic HOME_ERR,
	input wire logic [POS_W-1:0] CUR_POS
);
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	property p_req;
		HOME_REQ && AUTO_MANUAL_SELECT_BIT && POINT_SEL_BITS == '0 && !HOME_BUSY |=> HOME_BUSY || HOME_ERR;
	endproperty
	a_req: assert property (p_req) else $error("accepted request did not start");
	property p_refuse;
		!HOME_BUSY && (!AUTO_MANUAL_SELECT_BIT || POINT_SEL_BITS != '0) |=> !HOME_BUSY;
	endproperty
	a_refuse: assert property (p_refuse) else $error("start outside manual mode");
	property p_drop;
		HOME_BUSY && !AUTO_MANUAL_SELECT_BIT |=> !HOME_BUSY && HOME_ERR && !MOTION.enable;
	endproperty
	a_drop: assert property (p_drop) else $error("mode drop not aborted");
	property p_enable;
		MOTION.enable |-> HOME_BUSY;
	endproperty
	a_enable: assert property (p_enable) else $error("motion while idle");
	property p_ramp;
		MOTION.enable && $past(MOTION.enable) |-> $stable(MOTION.accel) && $stable(MOTION.decel);
	endproperty
	a_ramp: assert property (p_ramp) else $error("ramp times moved");
	property p_finish;
		$fell(HOME_BUSY) && HOME_DONE |-> !$past(MOTION.enable);
	endproperty
	a_finish: assert property (p_finish) else $error("done without stop");
	property p_track;
		HOME_BUSY && $past(HOME_BUSY) |-> CUR_POS - $past(CUR_POS) == $past(FB_POS) - $past(FB_POS, 2);
	endproperty
	a_track: assert property (p_track) else $error("position offset moved");
	property p_sticky;
		HOME_ERR && !WR |=> HOME_ERR;
	endproperty
	a_sticky: assert property (p_sticky) else $error("error flag lost");
	c_done: cover property ($rose(HOME_DONE));
	c_err: cover property ($rose(HOME_ERR));
	c_rev: cover property (MOTION.enable && MOTION.dir);
endmodule // hsrm_checker

// >>> sim/hsrm_master_model.sv
`timescale 1ns/10ps
module hsrm_master_model
	import hsrm_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic manual,
	input wire logic [7:0] pt,
	input wire logic go,
	input wire hsrm_motion_t motion,
	output logic auto_manual,
	output logic [7:0] point_sel,
	output logic pos_src,
	output logic home_req,
	output logic dog,
	output logic z,
	output logic [31:0] fb_pos
);
	logic go_d;
	assign pos_src = 1'b1; // Two-station layout
	// Axis moves one count a cycle; dog spans 40..60, index every 16 counts
	assign dog = $signed(fb_pos) >= 40 && $signed(fb_pos) <= 60;
	assign z = fb_pos[3:0] == 4'h0;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			auto_manual <= 1'b0;
			point_sel <= 8'h00;
			go_d <= 1'b0;
			home_req <= 1'b0;
			fb_pos <= 32'h0;
		end else begin
			auto_manual <= manual;
			point_sel <= pt;
			go_d <= go;
			home_req <= go_d; // Request lags the selection by a cycle
			if (motion.enable) begin
				fb_pos <= motion.dir ? fb_pos - 32'h1 : fb_pos + 32'h1;
			end
		end
	end
endmodule // hsrm_master_model

// >>> sim/tb.sv
`timescale 1ns/10ps
`define CHK(name, exp, got) \
	begin \
		cmp_count++; \
		if ((got) !== (exp)) begin \
			n_mismatch++; \
			$display("Error %s: expected %0h, seen %0h", name, exp, got); \
		end \
	end
module tb
	import hsrm_pkg::*;
;
	localparam logic [15:0] SRCH = 16'h0100;
	localparam logic [15:0] CRP = 16'h0010;
	localparam logic [15:0] ACC = 16'h0050;
	localparam logic [15:0] DEC = 16'h0060;
	localparam logic [31:0] HV = 32'h00001234;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic manual = 1'b0;
	logic [7:0] pt = 8'h00;
	logic go = 1'b0;
	logic [31:0] rdata, fb, cur;
	logic [7:0] ps;
	logic am, pss, hreq, dog, z, busy, done, err;
	hsrm_motion_t motion;
	int n_mismatch = 0;
	int cmp_count = 0;
	hsrm_top i_hsrm_top (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
		.RDATA(rdata), .AUTO_MANUAL_SELECT_BIT(am), .POINT_SEL_BITS(ps), .POS_SPEED_SOURCE_SELECT(pss),
		.HOME_REQ(hreq), .DOG_IN(dog), .ZPHASE_IN(z), .FB_POS(fb), .MOTION(motion), .HOME_BUSY(busy),
		.HOME_DONE(done), .HOME_ERR(err), .CUR_POS(cur));
	hsrm_master_model i_hsrm_master_model (.clk(clk), .rst_n(rst_n), .manual(manual), .pt(pt), .go(go),
		.motion(motion), .auto_manual(am), .point_sel(ps), .pos_src(pss), .home_req(hreq), .dog(dog),
		.z(z), .fb_pos(fb));
	initial begin
		forever #2.5 clk = ~clk;
	end
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic do_reset();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr_s <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		@(posedge clk);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		@(negedge clk);
		q = rdata;
	endtask
	task automatic req(input logic m, input logic [7:0] p);
		@(posedge clk);
		manual <= m;
		pt <= p;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (4) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic cfg(input logic [3:0] m, input logic d, input logic pol, input logic [31:0] sh);
		wr(HSRM_OFS_METHOD, {28'h0, m});
		wr(HSRM_OFS_DIRECTION, {31'h0, d});
		wr(HSRM_OFS_DOG_POL, {31'h0, pol});
		wr(HSRM_OFS_SEARCH_SPEED, {16'h0, SRCH});
		wr(HSRM_OFS_CREEP_SPEED, {16'h0, CRP});
		wr(HSRM_OFS_SHIFT, sh);
		wr(HSRM_OFS_HOME_VALUE, HV);
		wr(HSRM_OFS_PT1_ACCEL, {16'h0, ACC});
		wr(HSRM_OFS_PT1_DECEL, {16'h0, DEC});
	endtask
	task automatic s_regs();
		logic [31:0] q;
		do_reset();
		rd(HSRM_OFS_METHOD, q);
		`CHK("method_rst", 32'h7, q)
		rd(8'hfc, q);
		`CHK("unmapped", 32'h0, q)
		wr(HSRM_OFS_METHOD, 32'h8);
		rd(HSRM_OFS_METHOD, q);
		`CHK("method_wr", 32'h8, q)
	endtask
	task automatic home(input logic [3:0] m, input logic pol, input logic [31:0] sh, input logic [31:0] lat,
		input logic d2);
		logic [31:0] q;
		int i;
		do_reset();
		cfg(m, 1'b0, pol, sh);
		req(1'b1, 8'h00);
		`CHK("busy", 1'b1, busy)
		`CHK("search", SRCH, motion.speed)
		`CHK("accel", ACC, motion.accel)
		`CHK("decel", DEC, motion.decel)
		`CHK("dir", 1'b0, motion.dir)
		for (i = 0; i < 200 && motion.speed === SRCH; i++) @(negedge clk);
		`CHK("creep", CRP, motion.speed)
		`CHK("dir_creep", d2, motion.dir)
		for (i = 0; i < 300 && done !== 1'b1; i++) @(negedge clk);
		`CHK("done", 1'b1, done)
		`CHK("cur_pos", HV, cur)
		rd(HSRM_OFS_LATCH_POS, q);
		`CHK("latch", lat, q)
		rd(HSRM_OFS_CUR_POS, q);
		`CHK("cur_pos_reg", HV, q)
		rd(HSRM_OFS_STATUS, q);
		`CHK("status", 32'h0000001a, q)
		`CHK("stop", 1'b1, (d2 ? lat - sh - fb : fb - lat - sh) < 32'd3)
	endtask
	task automatic s_refuse();
		do_reset();
		cfg(4'h7, 1'b1, 1'b0, 32'h4);
		req(1'b1, 8'h80);
		`CHK("busy_pt", 1'b0, busy)
		req(1'b0, 8'h00);
		`CHK("busy_auto", 1'b0, busy)
		wr(HSRM_OFS_METHOD, 32'h5);
		req(1'b1, 8'h00);
		`CHK("err_code", 1'b1, err)
		`CHK("busy_code", 1'b0, busy)
		wr(HSRM_OFS_CONTROL, 32'h1);
		@(negedge clk);
		`CHK("err_clr", 1'b0, err)
		wr(HSRM_OFS_METHOD, 32'h9);
		req(1'b1, 8'h00);
		`CHK("dir_set", 1'b1, motion.dir)
		`CHK("busy_go", 1'b1, busy)
		req(1'b0, 8'h00);
		`CHK("err_drop", 1'b1, err)
		`CHK("busy_drop", 1'b0, busy)
	endtask
	// Whole run is a few hundred cycles; this only catches a hang
	initial begin
		#100000;
		n_mismatch++;
		stop_test();
	end
	initial begin
		s_regs();
		home(4'h7, 1'b0, 32'h4, 32'd48, 1'b0);
		home(4'h8, 1'b0, 32'h4, 32'd32, 1'b1);
		home(4'h9, 1'b0, 32'h4, 32'd40, 1'b0);
		home(4'h9, 1'b1, 32'h4, 32'd61, 1'b0); // Active-low dog edge is the far end
		s_refuse();
		stop_test();
	end
endmodule // tb
bind hsrm_top hsrm_checker #(.POS_W(POS_W)) i_hsrm_checker (.CLK(CLK), .RST_N(RST_N), .WR(WR),
	.AUTO_MANUAL_SELECT_BIT(AUTO_MANUAL_SELECT_BIT), .POINT_SEL_BITS(POINT_SEL_BITS), .HOME_REQ(HOME_REQ),
	.FB_POS(FB_POS), .MOTION(MOTION), .HOME_BUSY(HOME_BUSY), .HOME_DONE(HOME_DONE), .HOME_ERR(HOME_ERR),
	.CUR_POS(CUR_POS));
